// >>> timer_counter.v
`timescale 1ns/1ps
`include "timer_counter_defines.vh"
// Function
// - count only while run_enable is set; clearing it holds the count
// - width_select chooses 8-bit or 16-bit counting and overflow point
// - timer mode without prescaler advances once per cycle
// - after writing the count, increments are suppressed for two cycles
// - clock_source_select set counts external input transitions
// - count_edge_select 0 counts rising edges, 1 falling edges
// - external input is synchronised before counting, adding latency
// - an 8-bit prescaler sits in front, invisible to software
// - prescaler_bypass 0 uses prescaler, 1 bypasses it
// - prescale_select code n divides by two to the power n+1
// - count low writes clear the prescaler (high writes do not), assignment bit untouched
// - prescaler assignment may change at any time while running
// - rollover FFh->00h or FFFFh->0000h sets overflow_flag
// - interrupt request only when overflow_irq_enable is set
// - overflow request does not act as a wake-up; needs core clock
// - reading low byte in 16-bit mode copies true high byte to buffer
// - high writes load buffer; low write in 16-bit mode loads both bytes together
module timer_counter (
    input wire clk,
    input wire srst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire external_count_input,
    output reg overflow_irq
);
    reg [7:0] ctrl_q;
    reg [7:0] low_q;
    reg [7:0] high_q;
    reg [7:0] hbuf_q;
    reg [7:0] pre_q;
    reg ie_q;
    reg flag_q;
    reg [1:0] inhibit_q;
    reg sync1_q;
    reg sync2_q;
    reg prev_q;
    reg wr_q;
    reg [3:0] addr_q;
    reg rd_pend_q;
    reg [3:0] rd_addr_q;

    wire addr_ok = hsel && hready && htrans == `HTRANS_NONSEQ;
    wire wr_low = wr_q && addr_q == `ADDR_COUNT_LOW;
    wire wr_high = wr_q && addr_q == `ADDR_COUNT_HIGH;
    wire wr_ctrl = wr_q && addr_q == `ADDR_TIMER_CONTROL;
    wire wr_int = wr_q && addr_q == `ADDR_INT_CONTROL;
    wire is16 = !ctrl_q[`CTRL_WIDTH];
    wire rd_low = addr_ok && !hwrite && haddr[3:0] == `ADDR_COUNT_LOW;

    // selected edge on synchronised input
    wire ext_edge = ctrl_q[`CTRL_EDGE] ? (prev_q && !sync2_q)
                                       : (!prev_q && sync2_q);
    wire src_tick = ctrl_q[`CTRL_SRC] ? ext_edge : 1'b1;
    wire [7:0] pre_next = pre_q + 8'h01;
    wire [2:0] ps = ctrl_q[2:0];
    // last prescaler count before wrap: two to the power ps+1, minus one
    wire [8:0] pre_lim = (9'h002 << ps) - 9'h001;
    wire pre_done = {1'b0, pre_q} == pre_lim;
    wire gated = src_tick && ctrl_q[`CTRL_RUN] && inhibit_q == 2'd0;
    wire tick = ctrl_q[`CTRL_BYPASS] ? gated : (gated && pre_done);
    wire ovf = tick && low_q == 8'hff && (!is16 || high_q == 8'hff);

    always @(posedge clk) begin
        // two flip-flops before any logic sees the pin
        sync1_q <= external_count_input;
        sync2_q <= sync1_q;
        prev_q <= sync2_q;
    end

    always @(posedge clk) begin
        if (srst) begin
            ctrl_q <= `CTRL_RESET;
            hbuf_q <= `HIGH_RESET;
            low_q <= 8'h00;
            high_q <= 8'h00;
            pre_q <= 8'h00;
            ie_q <= 1'b0;
            flag_q <= 1'b0;
            inhibit_q <= 2'd0;
            wr_q <= 1'b0;
            addr_q <= 4'h0;
            rd_pend_q <= 1'b0;
            rd_addr_q <= 4'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            overflow_irq <= 1'b0;
        end else begin
            wr_q <= addr_ok && hwrite;
            addr_q <= haddr[3:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (wr_ctrl)
                ctrl_q <= hwdata[7:0];
            if (wr_high)
                hbuf_q <= hwdata[7:0];
            else if (rd_low && is16)
                hbuf_q <= high_q;
            if (wr_int)
                ie_q <= hwdata[`INT_IE];
            // hardware set beats software clear
            if (ovf)
                flag_q <= 1'b1;
            else if (wr_int)
                flag_q <= hwdata[`INT_IF];
            if (wr_low) begin
                low_q <= hwdata[7:0];
                if (is16)
                    high_q <= hbuf_q;
                inhibit_q <= `WRITE_INHIBIT;
                pre_q <= 8'h00;
            end else begin
                if (inhibit_q != 2'd0)
                    inhibit_q <= inhibit_q - 2'd1;
                if (gated && !ctrl_q[`CTRL_BYPASS])
                    pre_q <= pre_done ? 8'h00 : pre_next;
                if (tick) begin
                    low_q <= low_q + 8'h01;
                    if (is16 && low_q == 8'hff)
                        high_q <= high_q + 8'h01;
                end
            end
            // level request, no wake path from sleep
            overflow_irq <= (flag_q || ovf) && ie_q;
            rd_pend_q <= addr_ok && !hwrite;
            rd_addr_q <= haddr[3:0];
            hrdata <= 32'h0;
            if (addr_ok && !hwrite) begin
                case (haddr[3:0])
                    `ADDR_TIMER_CONTROL: hrdata <= {24'h0, ctrl_q};
                    `ADDR_COUNT_LOW: hrdata <= {24'h0, low_q};
                    `ADDR_COUNT_HIGH: hrdata <= {24'h0, hbuf_q};
                    `ADDR_INT_CONTROL:
                        hrdata <= {26'h0, ie_q, 2'b00, flag_q, 2'b00};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// >>> timer_counter_defines.vh
`ifndef TIMER_COUNTER_DEFINES_VH
`define TIMER_COUNTER_DEFINES_VH
`define ADDR_TIMER_CONTROL 4'h0
`define ADDR_COUNT_LOW 4'h4
`define ADDR_COUNT_HIGH 4'h8
`define ADDR_INT_CONTROL 4'hc
`define CTRL_RESET 8'hff
`define HIGH_RESET 8'h00
`define CTRL_RUN 7
`define CTRL_WIDTH 6
`define CTRL_SRC 5
`define CTRL_EDGE 4
`define CTRL_BYPASS 3
`define INT_IE 5
`define INT_IF 2
`define WRITE_INHIBIT 2'd2
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD 3'b010
`endif

// >>> timer_counter_assertions.sv
`timescale 1ns/1ps
module timer_counter_assertions (
    input wire clk, input wire srst, input wire hsel, input wire [31:0] haddr,
    input wire [1:0] htrans, input wire hwrite, input wire [2:0] hsize,
    input wire [31:0] hwdata, input wire hready, input wire [31:0] hrdata,
    input wire hreadyout, input wire hresp, input wire external_count_input,
    input wire overflow_irq
);
    wire acc = hsel && hready && htrans == 2'b10;
    wire wr_c = acc && hwrite && haddr[3:0] == 4'hc;
    wire rd_odd = acc && !hwrite && haddr[1:0] != 2'b00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=>
        hrdata == 32'h0 && !overflow_irq) else $error("reset not clean");
    a_release_quiet: assert property ($fell(srst) |-> !overflow_irq)
        else $error("irq high after reset");
    a_odd_zero: assert property (rd_odd |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_sticky: assert property (overflow_irq && !wr_c && !$past(wr_c)
        && !$past(wr_c, 2) |=> overflow_irq) else $error("irq dropped");
    a_irq_masked: assert property (wr_c ##1 !hwdata[5] |=> ##1
        !overflow_irq) else $error("irq not masked");
    a_irq_raise: assert property (wr_c ##1 hwdata[5] && hwdata[2] |=> ##1
        overflow_irq) else $error("irq not raised");
    c_write_int: cover property (wr_c);
    c_irq_rise: cover property ($rose(overflow_irq));
    c_odd_read: cover property (rd_odd);
endmodule
bind timer_counter timer_counter_assertions chk_i (.clk(clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .external_count_input(external_count_input), .overflow_irq(overflow_irq));

// >>> timer_counter_with_prescaler_bench.sv
`timescale 1ns/1ps
module timer_counter_with_prescaler_bench;
    logic clk = 0, srst = 1, hsel = 0, hwrite = 0, ext = 0;
    logic [31:0] haddr = 0, hwdata = 0, r;
    logic [1:0] htrans = 0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq;
    int n_mismatch = 0, total_checks = 0;
    always #5 clk = ~clk;
    timer_counter dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .external_count_input(ext), .overflow_irq(irq));
    task bus(input [3:0] a, input w, input [31:0] d);
        hsel <= 1; haddr <= {28'h0, a}; htrans <= 2'b10; hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 0; htrans <= 2'b00; hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task rd(input [3:0] a, input [31:0] e);
        bus(a, 0, 0);
        chk(r, e);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        rd(4'h0, 32'hff);
        rd(4'h8, 32'h0);
        rd(4'h1, 32'h0);
        $display("test reset done");
        bus(4'h0, 1, 32'h08);
        bus(4'h8, 1, 32'h12);
        bus(4'h4, 1, 32'h34);
        bus(4'h8, 1, 32'h56);
        rd(4'h4, 32'h34);
        rd(4'h8, 32'h12);
        $display("test wide access done");
        // seven toggles give four selected edges and three of the other kind
        for (int e = 0; e < 2; e++) begin
            bus(4'h0, 1, 32'he8 | (e << 4));
            bus(4'h4, 1, 32'h0);
            repeat (7) begin
                repeat (4) @(posedge clk);
                ext <= ~ext;
            end
            repeat (6) @(posedge clk);
            rd(4'h4, 32'h4);
        end
        $display("test external count done");
        bus(4'h0, 1, 32'hc8);
        bus(4'h4, 1, 32'hfe);
        repeat (8) @(posedge clk);
        bus(4'h0, 1, 32'h48);
        rd(4'h4, 32'h06);
        bus(4'hc, 0, 0);
        chk(r & 32'h24, 32'h04);
        chk(irq, 0);
        bus(4'hc, 1, 32'h24);
        repeat (2) @(posedge clk);
        chk(irq, 1);
        bus(4'hc, 1, 32'h04);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        $display("test overflow done");
        // prescaler 1:8 after the two inhibited cycles gives four ticks
        bus(4'h0, 1, 32'hc2);
        bus(4'h4, 1, 32'h0);
        repeat (34) @(posedge clk);
        rd(4'h4, 32'h04);
        $display("test prescaler done");
        wrap_up;
    end
endmodule
